// ### rtl/hsw_dev_end.sv
// Converter end: high-speed write receiver of the two-wire bus.
// Assumes scl and sda come from the hsw_if wired lines, and clk_sys
// is the core clock that receives the decoded words.
`timescale 1ns/100ps
module hsw_dev_end
(
  hsw_if.dev link,
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic pin_addr_bit_hi,
  input wire logic pin_addr_bit_lo,
  output logic [9:0] sample_word,
  output logic [1:0] sample_channel,
  output logic [1:0] sample_load,
  output logic sample_valid,
  output logic [1:0] pd_mode,
  output logic [1:0] pd_channel,
  output logic pd_valid,
  output logic hs_mode
);

  // ********************************************************
  // State types
  // ********************************************************
  typedef struct packed
  {
    logic [7:0] shift;
  } hsw_rx_type;

  typedef struct packed
  {
    hsw_pkg::hsw_phase_type phase;
    logic [3:0] cnt;
    logic start_seen;
    logic ack_oe;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [7:0] ctrl;
    logic [7:0] hi;
    logic [9:0] word;
    logic [1:0] pd;
    logic [2:0] tog;
  } hsw_link_type;

  typedef struct packed
  {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic hs;
    logic [9:0] word;
    logic [1:0] chan;
    logic [1:0] load;
    logic sv;
    logic [1:0] pdm;
    logic [1:0] pdch;
    logic pv;
  } hsw_sys_type;

  hsw_rx_type rx;
  hsw_rx_type next_rx;
  hsw_link_type ln;
  hsw_link_type next_ln;
  hsw_sys_type sy;
  hsw_sys_type next_sy;
  logic start_tog;
  logic stop_tog;
  logic [7:0] rx_byte;
  logic [3:0] ev;

  // ********************************************************
  // Start and stop detection on the data line edges
  // ********************************************************
  always_ff @(negedge link.sda or negedge rst_b)
  begin
    if (!rst_b)
      start_tog <= 1'b0;
    else if (link.scl)
      start_tog <= ~start_tog;
  end

  always_ff @(posedge link.sda or negedge rst_b)
  begin
    if (!rst_b)
      stop_tog <= 1'b0;
    else if (link.scl)
      stop_tog <= ~stop_tog;
  end

  // ********************************************************
  // Bit capture on the rising clock edge
  // ********************************************************
  always_comb
  begin
    next_rx = rx;
    next_rx.shift = {rx.shift[6:0], link.sda};
  end

  always_ff @(posedge link.scl or negedge rst_b)
  begin
    if (!rst_b)
      rx <= '0;
    else
      rx <= next_rx;
  end

  assign rx_byte = rx.shift;

  // ********************************************************
  // Byte sequencing and acknowledge on the falling edge
  // ********************************************************
  always_comb
  begin
    next_ln = ln;
    next_ln.pin_s1 = {pin_addr_bit_hi, pin_addr_bit_lo};
    next_ln.pin_s2 = ln.pin_s1;
    if (start_tog != ln.start_seen)
    begin
      next_ln.start_seen = start_tog;
      next_ln.phase = hsw_pkg::PH_ADDR;
      next_ln.cnt = 4'h0;
      next_ln.ack_oe = 1'b0;
    end
    else if (ln.cnt == hsw_pkg::ACK_SLOT)
    begin
      next_ln.ack_oe = 1'b0;
      next_ln.cnt = 4'h0;
    end
    else if (ln.cnt == hsw_pkg::BIT_LAST)
    begin
      next_ln.cnt = hsw_pkg::ACK_SLOT;
      case (ln.phase)
        hsw_pkg::PH_ADDR:
        begin
          if (rx_byte[7:3] == hsw_pkg::MC_PREFIX)
          begin
            next_ln.tog[2] = ~ln.tog[2];
            next_ln.phase = hsw_pkg::PH_IDLE;
          end
          else if (rx_byte[7:1] == {hsw_pkg::ADDR_FIXED, ln.pin_s2} &&
                   !rx_byte[0])
          begin
            next_ln.ack_oe = 1'b1;
            next_ln.phase = hsw_pkg::PH_CTRL;
          end
          else
          begin
            next_ln.phase = hsw_pkg::PH_IDLE;
          end
        end
        hsw_pkg::PH_CTRL:
        begin
          next_ln.ack_oe = 1'b1;
          next_ln.ctrl = rx_byte;
          if (rx_byte[hsw_pkg::CTRL_PD_SEL])
            next_ln.phase = hsw_pkg::PH_PD1;
          else
            next_ln.phase = hsw_pkg::PH_HI;
        end
        hsw_pkg::PH_HI:
        begin
          next_ln.ack_oe = 1'b1;
          next_ln.hi = rx_byte;
          next_ln.phase = hsw_pkg::PH_LO;
        end
        hsw_pkg::PH_LO:
        begin
          next_ln.ack_oe = 1'b1;
          next_ln.word = {ln.hi, rx_byte[7:6]};
          next_ln.tog[0] = ~ln.tog[0];
          next_ln.phase = hsw_pkg::PH_HI;
        end
        hsw_pkg::PH_PD1:
        begin
          next_ln.ack_oe = 1'b1;
          next_ln.pd = rx_byte[7:6];
          next_ln.phase = hsw_pkg::PH_PD2;
        end
        hsw_pkg::PH_PD2:
        begin
          next_ln.ack_oe = 1'b1;
          next_ln.tog[1] = ~ln.tog[1];
          next_ln.phase = hsw_pkg::PH_DONE;
        end
        default:
        begin
          next_ln.ack_oe = 1'b0;
        end
      endcase
    end
    else
    begin
      next_ln.cnt = ln.cnt + 4'h1;
    end
  end

  always_ff @(negedge link.scl or negedge rst_b)
  begin
    if (!rst_b)
      ln <= '{phase: hsw_pkg::PH_IDLE, default: '0};
    else
      ln <= next_ln;
  end

  assign link.d_sda_oe = ln.ack_oe;
  assign link.d_sda_out = 1'b0;

  // ********************************************************
  // Hand-over to the core clock
  // ********************************************************
  assign ev = sy.s2 ^ sy.s3;

  always_comb
  begin
    next_sy = sy;
    next_sy.s1 = {stop_tog, ln.tog};
    next_sy.s2 = sy.s1;
    next_sy.s3 = sy.s2;
    next_sy.sv = ev[0];
    next_sy.pv = ev[1];
    if (ev[0])
    begin
      next_sy.word = ln.word;
      next_sy.chan = ln.ctrl[hsw_pkg::CTRL_CHAN_LSB +: 2];
      next_sy.load = ln.ctrl[hsw_pkg::CTRL_LOAD_LSB +: 2];
    end
    if (ev[1])
    begin
      next_sy.pdm = ln.pd;
      next_sy.pdch = ln.ctrl[hsw_pkg::CTRL_CHAN_LSB +: 2];
    end
    if (ev[3])
      next_sy.hs = 1'b0;
    if (ev[2])
      next_sy.hs = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      sy <= '0;
    else
      sy <= next_sy;
  end

  assign sample_word = sy.word;
  assign sample_channel = sy.chan;
  assign sample_load = sy.load;
  assign sample_valid = sy.sv;
  assign pd_mode = sy.pdm;
  assign pd_channel = sy.pdch;
  assign pd_valid = sy.pv;
  assign hs_mode = sy.hs;

endmodule : hsw_dev_end

// ### rtl/hsw_if.sv
// Two-wire bus joining the master end and the converter end.
// Both lines are open drain with a pull-up modelled here.
`timescale 1ns/100ps
interface hsw_if;
  logic scl_out;
  logic scl_oe;
  logic m_sda_out;
  logic m_sda_oe;
  logic d_sda_out;
  logic d_sda_oe;
  logic scl;
  logic sda;

  // ********************************************************
  // Wired-AND line levels
  // ********************************************************
  assign scl = ~(scl_oe & ~scl_out);
  assign sda = ~((m_sda_oe & ~m_sda_out) | (d_sda_oe & ~d_sda_out));

  modport mst
  (
    output scl_out,
    output scl_oe,
    output m_sda_out,
    output m_sda_oe,
    input scl,
    input sda
  );

  modport dev
  (
    output d_sda_out,
    output d_sda_oe,
    input scl,
    input sda
  );
endinterface : hsw_if

// ### rtl/hsw_mst_end.sv
// Master end: sends high-speed writes to the converter end.
// Assumes hsw_if wired lines and clk_sys as the only clock; the
// bus clock is divided from clk_sys and driven out.
`timescale 1ns/100ps
module hsw_mst_end
#(
  parameter int FS_QTR = hsw_pkg::FS_QTR_CYC,
  parameter int HS_QTR = hsw_pkg::HS_QTR_CYC
)
(
  hsw_if.mst link,
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_addr_sel,
  input wire logic [1:0] cmd_channel,
  input wire logic [1:0] cmd_load,
  input wire logic cmd_pd_sel,
  input wire logic [1:0] cmd_pd_mode,
  input wire logic [9:0] cmd_word,
  input wire logic cmd_stop,
  output logic done,
  output logic nack_err,
  output logic busy
);

  localparam int DW = $clog2(FS_QTR + 1);

  generate
    if (HS_QTR < 3 || FS_QTR < HS_QTR)
    begin : g_bad_div
      $error("hsw_mst_end: quarter counts unusable");
    end
  endgenerate

  typedef struct packed
  {
    hsw_pkg::hsw_mstate_type st;
    logic [1:0] qtr;
    logic [DW-1:0] div;
    logic [3:0] bits;
    logic [2:0] idx;
    logic hs;
    logic scl_low;
    logic sda_low;
    logic [7:0] sh;
    logic [19:0] cmd;
    logic s1;
    logic s2;
    logic ready;
    logic done;
    logic err;
    logic busy;
  } hsw_mst_type;

  hsw_mst_type q;
  hsw_mst_type next_q;
  logic [DW-1:0] qlen;
  logic tick;

  // ********************************************************
  // Byte source
  // ********************************************************
  function automatic logic [7:0] byte_of
  (
    input logic [2:0] idx,
    input logic [19:0] c
  );
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      3'h0: b = {hsw_pkg::MC_PREFIX, hsw_pkg::MC_ID};
      3'h1: b = {hsw_pkg::ADDR_FIXED, c[19:18], 1'b0};
      3'h2: b = {2'h0, c[15:14], 1'b0, c[17:16], c[13]};
      3'h3: b = c[13] ? {c[12:11], 6'h00} : c[9:2];
      3'h4: b = c[13] ? 8'h00 : {c[1:0], 6'h00};
      default: b = 8'h00;
    endcase
    return b;
  endfunction : byte_of

  // ********************************************************
  // Sequencer
  // ********************************************************
  assign qlen = q.hs ? DW'(HS_QTR - 1) : DW'(FS_QTR - 1);
  assign tick = (q.div == qlen);

  always_comb
  begin
    next_q = q;
    next_q.s1 = link.sda;
    next_q.s2 = q.s1;
    next_q.done = 1'b0;
    next_q.err = 1'b0;
    next_q.div = tick ? '0 : q.div + 1'b1;
    case (q.st)
      hsw_pkg::M_IDLE, hsw_pkg::M_HOLD:
      begin
        next_q.div = '0;
        next_q.qtr = 2'h0;
        if (cmd_valid && q.ready)
        begin
          next_q.cmd = {cmd_addr_sel, cmd_channel, cmd_load, cmd_pd_sel,
                        cmd_pd_mode, cmd_stop, cmd_word};
          next_q.ready = 1'b0;
          next_q.busy = 1'b1;
          next_q.st = (q.st == hsw_pkg::M_IDLE) ? hsw_pkg::M_START
                                                : hsw_pkg::M_RSTART;
        end
      end
      hsw_pkg::M_START:
      begin
        if (tick)
        begin
          next_q.qtr = q.qtr + 2'h1;
          if (q.qtr == 2'h0)
            next_q.sda_low = 1'b1;
          else
          begin
            next_q.scl_low = 1'b1;
            next_q.st = hsw_pkg::M_BYTE;
            next_q.qtr = 2'h0;
            next_q.bits = 4'h0;
            next_q.idx = 3'h0;
            next_q.sh = byte_of(3'h0, q.cmd);
          end
        end
      end
      hsw_pkg::M_BYTE:
      begin
        if (tick)
        begin
          next_q.qtr = q.qtr + 2'h1;
          case (q.qtr)
            2'h0: next_q.sda_low = (q.bits != hsw_pkg::ACK_SLOT) & ~q.sh[7];
            2'h1: next_q.scl_low = 1'b0;
            2'h3:
            begin
              next_q.scl_low = 1'b1;
              next_q.sh = {q.sh[6:0], 1'b0};
              next_q.bits = q.bits + 4'h1;
              if (q.bits == hsw_pkg::ACK_SLOT)
              begin
                next_q.bits = 4'h0;
                next_q.idx = q.idx + 3'h1;
                next_q.sh = byte_of(q.idx + 3'h1, q.cmd);
                if (q.idx == 3'h0)
                begin
                  next_q.hs = 1'b1;
                  next_q.st = hsw_pkg::M_RSTART;
                end
                else if (q.s2)
                begin
                  next_q.err = 1'b1;
                  next_q.st = hsw_pkg::M_STOP;
                end
                else if (q.idx == 3'h4)
                  next_q.st = q.cmd[10] ? hsw_pkg::M_STOP : hsw_pkg::M_HOLD;
              end
            end
            default: next_q.qtr = 2'h3;
          endcase
        end
      end
      hsw_pkg::M_RSTART:
      begin
        if (tick)
        begin
          next_q.qtr = q.qtr + 2'h1;
          case (q.qtr)
            2'h0: next_q.sda_low = 1'b0;
            2'h1: next_q.scl_low = 1'b0;
            2'h2: next_q.sda_low = 1'b1;
            default:
            begin
              next_q.scl_low = 1'b1;
              next_q.st = hsw_pkg::M_BYTE;
              next_q.bits = 4'h0;
              next_q.idx = 3'h1;
              next_q.sh = byte_of(3'h1, q.cmd);
            end
          endcase
        end
      end
      hsw_pkg::M_STOP:
      begin
        if (tick)
        begin
          next_q.qtr = q.qtr + 2'h1;
          case (q.qtr)
            2'h0: next_q.sda_low = 1'b1;
            2'h1: next_q.scl_low = 1'b0;
            default:
            begin
              next_q.sda_low = 1'b0;
              next_q.hs = 1'b0;
              next_q.st = hsw_pkg::M_IDLE;
            end
          endcase
        end
      end
      default: next_q.st = hsw_pkg::M_IDLE;
    endcase
    if ((next_q.st == hsw_pkg::M_IDLE || next_q.st == hsw_pkg::M_HOLD) &&
        q.busy && !(q.st == hsw_pkg::M_IDLE || q.st == hsw_pkg::M_HOLD))
    begin
      next_q.done = 1'b1;
      next_q.busy = 1'b0;
      next_q.ready = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      q <= '{st: hsw_pkg::M_IDLE, ready: 1'b1, s1: 1'b1, s2: 1'b1,
             default: '0};
    else
      q <= next_q;
  end

  assign link.scl_oe = q.scl_low;
  assign link.scl_out = 1'b0;
  assign link.m_sda_oe = q.sda_low;
  assign link.m_sda_out = 1'b0;
  assign cmd_ready = q.ready;
  assign done = q.done;
  assign nack_err = q.err;
  assign busy = q.busy;

endmodule : hsw_mst_end

// ### rtl/hsw_pkg.sv
// Shared constants and types of the high-speed write link.
// Assumes a two-wire bus with one master end and one converter end.
package hsw_pkg;

  // ********************************************************
  // Byte layout
  // ********************************************************
  localparam logic [4:0] ADDR_FIXED = 5'h13;
  localparam logic [4:0] MC_PREFIX = 5'h01;
  // Low three master-code bits: arbitrary value
  localparam logic [2:0] MC_ID = 3'h0;
  localparam int CTRL_PD_SEL = 0;
  localparam int CTRL_CHAN_LSB = 1;
  localparam int CTRL_LOAD_LSB = 4;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int FS_PERIOD_NS = 2500;
  localparam int HS_PERIOD_NS = 400;
  localparam int FS_QTR_CYC =
    (FS_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int HS_QTR_CYC =
    (HS_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  // ********************************************************
  // States
  // ********************************************************
  typedef enum logic [2:0]
  {
    PH_IDLE,
    PH_ADDR,
    PH_CTRL,
    PH_HI,
    PH_LO,
    PH_PD1,
    PH_PD2,
    PH_DONE
  } hsw_phase_type;

  typedef enum logic [2:0]
  {
    M_IDLE,
    M_START,
    M_BYTE,
    M_RSTART,
    M_STOP,
    M_HOLD
  } hsw_mstate_type;

endpackage : hsw_pkg

// ### verification/hsw_link_properties.sv
// Bus checker of the high-speed write link.
// Assumes the wired lines of hsw_if, sampled in the clk_sys domain.
`timescale 1ns/100ps
module hsw_link_properties
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic m_sda_out,
  input wire logic m_sda_oe,
  input wire logic d_sda_out,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic idle;
  logic first_frame;
  logic [3:0] cnt;
  logic [2:0] byte_n;
  logic [1:0] ack_hi;
  logic rise;
  logic start_seen;
  assign rise = scl & ~scl_q;
  assign start_seen = scl & scl_q & sda_q & ~sda;

  // ************************************************************
  // Frame tracking
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      idle <= 1'b1;
      first_frame <= 1'b0;
      cnt <= 4'h0;
      byte_n <= 3'h0;
      ack_hi <= 2'h0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      ack_hi <= !d_sda_oe ? 2'h0 : ack_hi + {1'b0, rise & ~ack_hi[1]};
      if (start_seen)
      begin
        cnt <= 4'h0;
        byte_n <= 3'h0;
        first_frame <= idle;
        idle <= 1'b0;
      end
      else if (scl & scl_q & ~sda_q & sda)
        idle <= 1'b1;
      else if (rise)
      begin
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        if (cnt == 4'h8 && byte_n != 3'h7)
          byte_n <= byte_n + 3'h1;
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  AST_OPEN_DRAIN: assert property (!d_sda_out && !m_sda_out && !scl_out)
    else $error("line driven high");
  AST_ACK_SCL_LOW: assert property ($rose(d_sda_oe) |-> !scl)
    else $error("ack raised with clock high");
  AST_DEV_HOLD: assert property (
    scl && $past(scl) |-> $stable(d_sda_oe))
    else $error("device data moved with clock high");
  AST_ACK_ONE_CLK: assert property (ack_hi <= 2'h1)
    else $error("ack held over two clocks");
  AST_ACK_SLOT: assert property (
    d_sda_oe |-> (cnt == 4'h8 || cnt == 4'h0)
    && !(first_frame && byte_n == 3'h0))
    else $error("device pulled outside ack slot");
  AST_MC_PREFIX: assert property (
    first_frame && byte_n == 3'h0 && rise && cnt < 4'h5
    |-> sda == hsw_pkg::MC_PREFIX[3'h4 - cnt[2:0]])
    else $error("bad master code bit");
  AST_MC_NACK: assert property (
    first_frame && byte_n == 3'h0 && rise && cnt == 4'h8 |-> sda)
    else $error("master code acknowledged");
  AST_ADDR_FIXED: assert property (
    !first_frame && byte_n == 3'h0 && rise && cnt < 4'h5
    |-> sda == hsw_pkg::ADDR_FIXED[3'h4 - cnt[2:0]])
    else $error("bad fixed address bit");
  AST_ADDR_WRITE: assert property (
    !first_frame && byte_n == 3'h0 && rise && cnt == 4'h7 |-> !sda)
    else $error("address not in write direction");
  // start or stop only, after the set-up rise that follows an ack, or while idle
  AST_MST_SDA_HIGH: assert property (
    scl && $past(scl) && $changed(m_sda_oe) |-> cnt == 4'h1 || idle)
    else $error("master data moved inside a byte");
endmodule : hsw_link_properties

// ### verification/tb.sv
// Testbench of the high-speed write link with both ends joined.
// Assumes hsw_if, hsw_dev_end and hsw_mst_end from rtl/.
`timescale 1ns/100ps
module tb;
  typedef struct packed
  {
    logic pd;
    logic [1:0] ch;
    logic [1:0] load;
    logic [9:0] word;
  } hsw_note_type;

  logic clk_sys;
  logic rst_b;
  logic [1:0] pins;
  logic cmd_valid;
  logic cmd_ready;
  logic [1:0] cmd_addr_sel;
  logic [1:0] cmd_channel;
  logic [1:0] cmd_load;
  logic cmd_pd_sel;
  logic [1:0] cmd_pd_mode;
  logic [9:0] cmd_word;
  logic cmd_stop;
  logic done;
  logic nack_err;
  logic busy;
  logic [9:0] sample_word;
  logic [1:0] sample_channel;
  logic [1:0] sample_load;
  logic sample_valid;
  logic [1:0] pd_mode;
  logic [1:0] pd_channel;
  logic pd_valid;
  logic hs_mode;
  logic nack_seen;
  logic [31:0] seed;
  int err_total;
  int samples_checked;
  hsw_note_type notes[$];
  hsw_note_type exp;

  hsw_if link();
  hsw_dev_end i_hsw_dev_end(.link(link), .clk_sys(clk_sys), .rst_b(rst_b),
    .pin_addr_bit_hi(pins[1]), .pin_addr_bit_lo(pins[0]),
    .sample_word(sample_word), .sample_channel(sample_channel),
    .sample_load(sample_load), .sample_valid(sample_valid),
    .pd_mode(pd_mode), .pd_channel(pd_channel), .pd_valid(pd_valid),
    .hs_mode(hs_mode));
  hsw_mst_end #(.FS_QTR(3), .HS_QTR(3)) i_hsw_mst_end(.link(link),
    .clk_sys(clk_sys), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_addr_sel(cmd_addr_sel),
    .cmd_channel(cmd_channel), .cmd_load(cmd_load),
    .cmd_pd_sel(cmd_pd_sel), .cmd_pd_mode(cmd_pd_mode),
    .cmd_word(cmd_word), .cmd_stop(cmd_stop), .done(done),
    .nack_err(nack_err), .busy(busy));
  hsw_link_properties i_hsw_link_properties(.clk_sys(clk_sys),
    .rst_b(rst_b), .scl_out(link.scl_out), .scl_oe(link.scl_oe),
    .m_sda_out(link.m_sda_out), .m_sda_oe(link.m_sda_oe),
    .d_sda_out(link.d_sda_out), .d_sda_oe(link.d_sda_oe),
    .scl(link.scl), .sda(link.sda));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] rnd_next(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : rnd_next

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      err_total++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic results();
    $display("Counts: %0d checked, %0d mismatches", samples_checked,
      err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  // Command v: word in 9:0, channel 11:10, load 13:12
  task automatic send(input logic [1:0] sel, input logic pd_sel,
    input logic stop, input logic ack, input logic [15:0] v);
    hsw_note_type note;
    int n;
    note = {pd_sel, v[11:10], v[13:12], v[9:0]};
    @(negedge clk_sys);
    cmd_addr_sel = sel;
    cmd_channel = v[11:10];
    cmd_load = v[13:12];
    cmd_pd_sel = pd_sel;
    cmd_pd_mode = v[1:0];
    cmd_word = v[9:0];
    cmd_stop = stop;
    cmd_valid = 1'b1;
    nack_seen = 1'b0;
    if (ack)
      notes.push_back(note);
    for (n = 0; n < 50 && cmd_ready !== 1'b1; n++)
      @(negedge clk_sys);
    if (cmd_ready !== 1'b1)
    begin
      chk(16'h0001, 16'h0000);
      results();
    end
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    chk({14'h0000, busy, cmd_ready}, 16'h0002);
    for (n = 0; n < 4000 && done !== 1'b1; n++)
      @(negedge clk_sys);
    if (n == 4000)
    begin
      chk(16'h0001, 16'h0000);
      results();
    end
    chk({15'h0000, nack_seen}, {15'h0000, !ack});
    chk({14'h0000, busy, cmd_ready}, 16'h0001);
  endtask : send

  task automatic wait_slow();
    int n;
    for (n = 0; n < 40 && hs_mode !== 1'b0; n++)
      @(negedge clk_sys);
    chk({15'h0000, hs_mode}, 16'h0000);
    if (hs_mode !== 1'b0)
      results();
  endtask : wait_slow

  // ************************************************************
  // Output monitor
  // ************************************************************
  always @(negedge clk_sys)
  begin
    if (nack_err === 1'b1)
      nack_seen = 1'b1;
    if (sample_valid === 1'b1 || pd_valid === 1'b1)
    begin
      if (notes.size() == 0)
        chk(16'h0001, 16'h0000);
      else
      begin
        exp = notes.pop_front();
        chk({14'h0000, pd_valid, sample_valid},
          {14'h0000, exp.pd, !exp.pd});
        if (exp.pd)
        begin
          chk({14'h0000, pd_mode}, {14'h0000, exp.word[1:0]});
          chk({14'h0000, pd_channel}, {14'h0000, exp.ch});
        end
        else
        begin
          chk({6'h00, sample_word}, {6'h00, exp.word});
          chk({14'h0000, sample_channel}, {14'h0000, exp.ch});
          chk({14'h0000, sample_load}, {14'h0000, exp.load});
        end
      end
    end
  end

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    err_total = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_addr_sel = 2'h0;
    cmd_channel = 2'h0;
    cmd_load = 2'h0;
    cmd_pd_sel = 1'b0;
    cmd_pd_mode = 2'h0;
    cmd_word = 10'h000;
    cmd_stop = 1'b0;
    nack_seen = 1'b0;
    seed = rnd_next(32'h0000_001d);
    pins = seed[1:0];
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      seed = rnd_next(seed);
      if (i < 2)
        seed[9:0] = (i == 0) ? 10'h3ff : 10'h000;
      send(pins, 1'b0, i == 3, 1'b1, {seed[15:12], i[1:0], seed[9:0]});
      // Stop reaches hs_mode only a few cycles after done
      if (i == 3)
        wait_slow();
      chk({15'h0000, hs_mode}, {15'h0000, i != 3});
    end
    wait_slow();
    $display("Test data words done");
    for (int m = 0; m < 4; m++)
    begin
      seed = rnd_next(seed);
      send(pins, 1'b1, m[0], 1'b1, {seed[15:10], 8'h00, m[1:0]});
    end
    wait_slow();
    $display("Test power-down words done");
    seed = rnd_next(seed);
    send(pins ^ 2'h1, 1'b0, 1'b1, 1'b0, seed[15:0]);
    send(pins, 1'b0, 1'b1, 1'b1, seed[15:0]);
    repeat (20) @(negedge clk_sys);
    chk(16'(notes.size()), 16'h0000);
    $display("Test foreign address done");
    results();
  end
endmodule : tb
